//--- eea_pkg.sv
package eea_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_SUBSYS = 8'h6c;
    localparam logic [7:0] OFF_CTL = 8'h70;
    localparam logic [7:0] OFF_RSVD = 8'h74;
    localparam logic [7:0] OFF_IRQ_STS = 8'h80;
    localparam logic [7:0] OFF_IRQ_EN = 8'h84;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h88;
    // control/status field positions
    localparam int CTL_GO = 0;
    localparam int CTL_CMD = 1;
    localparam int CTL_ERR = 2;
    localparam int CTL_ALDONE = 3;
    localparam int CTL_DIV = 4;
    localparam int CTL_ALDIS = 6;
    localparam int CTL_FAST = 7;
    localparam int CTL_ALBUSY = 8;
    localparam int CTL_ADR = 9;
    localparam int CTL_DAT = 16;
    // reset values
    localparam logic [1:0] DIV_RESET = 2'h0;
    localparam logic FAST_RESET = 1'b1;
    localparam logic [15:0] SUBSYS_RESET = 16'h0000;
    // serial clock divisors of the core clock
    localparam logic [12:0] DIV_SEL0 = 13'h1000;
    localparam logic [12:0] DIV_SEL1 = 13'h0800;
    localparam logic [12:0] DIV_SEL2 = 13'h0400;
    localparam logic [12:0] DIV_SEL3 = 13'h0080;
    localparam int FAST_SHIFT = 5;
    // frame layout: slot indices
    localparam logic [4:0] ACK0 = 5'h08;
    localparam logic [4:0] ACK1 = 5'h11;
    localparam logic [4:0] ACK2 = 5'h1a;
    localparam logic [4:0] WR_LAST = 5'h1a;
    localparam logic [4:0] RD_LAST = 5'h18;
    // interrupt bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR = 1;
    localparam int IRQ_AL = 2;
    localparam int IRQ_W = 3;
    // serial engine states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_START = 4'b0010,
        ST_BITS = 4'b0100,
        ST_STOP = 4'b1000
    } eea_state_t;
endpackage

//--- eea_autoload.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - cycle-start bit self-clears when access finishes
// - writing start 0->1 launches read/write access
// - missing acknowledge sets error flag
// - autoload-done reads one after successful autoload
// - two-bit divisor field picks serial clock rate
// - autoload control zero enables, one disables
// - fast bit makes autoload 32x faster
// - in-progress flag high while autoload runs
// - seven-bit word address addresses the access
// - sixteen-bit data field holds write word
// - read-only subsystem_vendor_ident low half
// - read-only subsystem_ident upper half
module eea_autoload (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // serial eeprom pins
    output logic ee_scl,
    input wire logic ee_sda_i,
    output logic ee_sda_o,
    output logic ee_sda_oe_n,
    // interrupt
    output logic irq
);
    // divider half period, in core clocks minus one
    function automatic logic [11:0] div_half(input logic [1:0] sel, input logic fast);
        logic [12:0] b;
        b = eea_pkg::DIV_SEL0;
        case (sel)
            2'h1: b = eea_pkg::DIV_SEL1;
            2'h2: b = eea_pkg::DIV_SEL2;
            2'h3: b = eea_pkg::DIV_SEL3;
            default: b = eea_pkg::DIV_SEL0;
        endcase
        if (fast) begin
            b = b >> eea_pkg::FAST_SHIFT;
        end
        return 12'(b >> 1) - 12'h001;
    endfunction

    // control fields
    logic go_r, go_nxt;
    logic cmd_r, cmd_nxt;
    logic err_r, err_nxt;
    logic [1:0] div_r, div_nxt;
    logic aldis_r, aldis_nxt;
    logic fast_r, fast_nxt;
    logic [6:0] adr_r, adr_nxt;
    logic [15:0] dat_r, dat_nxt;
    // autoload state
    logic al_pend_r, al_pend_nxt; // autoload still to run
    logic al_busy_r, al_busy_nxt;
    logic al_done_r, al_done_nxt;
    logic al_idx_r, al_idx_nxt; // 0: vendor word, 1: id word
    logic [15:0] svid_r, svid_nxt;
    logic [15:0] sid_r, sid_nxt;
    // serial engine
    eea_pkg::eea_state_t st_r, st_nxt;
    logic cyc_busy_r, cyc_busy_nxt; // software access in flight
    logic wr_cyc_r, wr_cyc_nxt; // current frame writes
    logic [11:0] cnt_r, cnt_nxt;
    logic [1:0] ph_r, ph_nxt;
    logic [4:0] idx_r, idx_nxt;
    logic [26:0] tx_r, tx_nxt;
    logic [15:0] rx_r, rx_nxt;
    logic scl_r, scl_nxt;
    logic drv_r, drv_nxt; // 1 pulls data line low
    // interrupts and bus
    logic [eea_pkg::IRQ_W-1:0] sts_r, sts_nxt, en_r, en_nxt, ev;
    logic [31:0] rdata_r, rdata_nxt;
    logic [31:0] ctl_view;
    logic tick, launch_al, launch_sw, ack_slot, fin;

    // divider runs only during a frame so idle costs no toggling
    assign tick = (st_r != eea_pkg::ST_IDLE) && (cnt_r == 12'h000);
    assign ack_slot = (idx_r == eea_pkg::ACK0) ||
        (wr_cyc_r && ((idx_r == eea_pkg::ACK1) || (idx_r == eea_pkg::ACK2)));
    // autoload has priority over a software access
    assign launch_al = (st_r == eea_pkg::ST_IDLE) && al_pend_r && !aldis_r;
    assign launch_sw = (st_r == eea_pkg::ST_IDLE) && go_r && !cyc_busy_r &&
        !launch_al && !al_busy_r && !al_pend_r;
    assign fin = (st_r == eea_pkg::ST_STOP) && tick && (ph_r == 2'h2);

    // status word as software sees it
    always_comb begin
        ctl_view = {dat_r, adr_r, al_busy_r, fast_r, aldis_r, div_r,
            al_done_r, err_r, cmd_r, go_r};
    end

    // next-state logic for every register
    always_comb begin
        go_nxt = go_r;
        cmd_nxt = cmd_r;
        err_nxt = err_r;
        div_nxt = div_r;
        aldis_nxt = aldis_r;
        fast_nxt = fast_r;
        adr_nxt = adr_r;
        dat_nxt = dat_r;
        al_pend_nxt = al_pend_r;
        al_busy_nxt = al_busy_r;
        al_done_nxt = al_done_r;
        al_idx_nxt = al_idx_r;
        svid_nxt = svid_r;
        sid_nxt = sid_r;
        st_nxt = st_r;
        cyc_busy_nxt = cyc_busy_r;
        wr_cyc_nxt = wr_cyc_r;
        cnt_nxt = cnt_r;
        ph_nxt = ph_r;
        idx_nxt = idx_r;
        tx_nxt = tx_r;
        rx_nxt = rx_r;
        scl_nxt = scl_r;
        drv_nxt = drv_r;
        en_nxt = en_r;
        ev = '0;
        rdata_nxt = 32'h0000_0000;
        // software writes, lowest priority
        if (wr && addr == eea_pkg::OFF_CTL) begin
            go_nxt = go_r | wdata[eea_pkg::CTL_GO];
            cmd_nxt = wdata[eea_pkg::CTL_CMD];
            div_nxt = wdata[eea_pkg::CTL_DIV+:2];
            aldis_nxt = wdata[eea_pkg::CTL_ALDIS];
            fast_nxt = wdata[eea_pkg::CTL_FAST];
            adr_nxt = wdata[eea_pkg::CTL_ADR+:7];
            dat_nxt = wdata[eea_pkg::CTL_DAT+:16];
        end else if (wr && addr == eea_pkg::OFF_IRQ_EN) begin
            en_nxt = wdata[eea_pkg::IRQ_W-1:0];
        end
        // read answer, one cycle later
        if (rd) begin
            if (addr == eea_pkg::OFF_SUBSYS) begin
                rdata_nxt = {sid_r, svid_r};
            end else if (addr == eea_pkg::OFF_CTL) begin
                rdata_nxt = ctl_view;
            end else if (addr == eea_pkg::OFF_IRQ_STS) begin
                rdata_nxt = {29'h0, sts_r};
            end else if (addr == eea_pkg::OFF_IRQ_EN) begin
                rdata_nxt = {29'h0, en_r};
            end else begin
                rdata_nxt = 32'h0000_0000;
            end
        end
        // disabled while a word is still to load: the load is dropped, done stays low
        if (al_pend_r && aldis_r && st_r == eea_pkg::ST_IDLE) begin
            al_pend_nxt = 1'b0;
            al_busy_nxt = 1'b0;
        end
        // divider
        if (st_r == eea_pkg::ST_IDLE || tick) begin
            cnt_nxt = div_half(div_r, fast_r && (al_busy_r || launch_al));
        end else begin
            cnt_nxt = cnt_r - 12'h001;
        end
        case (st_r)
            eea_pkg::ST_IDLE: begin
                scl_nxt = 1'b1;
                drv_nxt = 1'b0;
                if (launch_al) begin
                    al_pend_nxt = 1'b0;
                    al_busy_nxt = 1'b1;
                    err_nxt = 1'b0;
                    wr_cyc_nxt = 1'b0;
                    tx_nxt = {6'h00, al_idx_r, 1'b1, 19'h7ffff};
                    st_nxt = eea_pkg::ST_START;
                end else if (launch_sw) begin
                    cyc_busy_nxt = 1'b1;
                    err_nxt = 1'b0;
                    wr_cyc_nxt = cmd_r;
                    // a read leaves the data slots released so the eeprom can drive them
                    tx_nxt = {adr_r, ~cmd_r, 1'b1, cmd_r ? dat_r[15:8] : 8'hff, 1'b1,
                        cmd_r ? dat_r[7:0] : 8'hff, 1'b1};
                    st_nxt = eea_pkg::ST_START;
                end
            end
            eea_pkg::ST_START: begin
                // data falls while clock high
                if (tick) begin
                    drv_nxt = 1'b1;
                    ph_nxt = 2'h0;
                    idx_nxt = 5'h00;
                    st_nxt = eea_pkg::ST_BITS;
                end
            end
            eea_pkg::ST_BITS: begin
                if (tick && ph_r == 2'h0) begin
                    scl_nxt = 1'b0;
                    drv_nxt = ~tx_r[5'h1a - idx_r];
                    ph_nxt = 2'h1;
                end else if (tick) begin
                    scl_nxt = 1'b1;
                    ph_nxt = 2'h0;
                    if (ack_slot && ee_sda_i) begin
                        err_nxt = 1'b1;
                        ev[eea_pkg::IRQ_ERR] = 1'b1;
                    end
                    if (!wr_cyc_r && idx_r > eea_pkg::ACK0) begin
                        rx_nxt = {rx_r[14:0], ee_sda_i};
                    end
                    idx_nxt = idx_r + 5'h01;
                    if (idx_r == (wr_cyc_r ? eea_pkg::WR_LAST : eea_pkg::RD_LAST)) begin
                        st_nxt = eea_pkg::ST_STOP;
                    end
                end
            end
            eea_pkg::ST_STOP: begin
                // clock low with data low, clock high, then data rises
                if (tick && ph_r == 2'h0) begin
                    scl_nxt = 1'b0;
                    drv_nxt = 1'b1;
                    ph_nxt = 2'h1;
                end else if (tick && ph_r == 2'h1) begin
                    scl_nxt = 1'b1;
                    ph_nxt = 2'h2;
                end else if (fin) begin
                    drv_nxt = 1'b0;
                    ph_nxt = 2'h0;
                    st_nxt = eea_pkg::ST_IDLE;
                    if (al_busy_r) begin
                        // an error abandons the load, done stays low
                        if (err_r) begin
                            al_busy_nxt = 1'b0;
                        end else if (al_idx_r) begin
                            sid_nxt = rx_r;
                            al_busy_nxt = 1'b0;
                            al_done_nxt = 1'b1;
                            ev[eea_pkg::IRQ_AL] = 1'b1;
                        end else begin
                            svid_nxt = rx_r;
                            al_idx_nxt = 1'b1;
                            al_pend_nxt = 1'b1;
                        end
                    end else begin
                        go_nxt = 1'b0;
                        cyc_busy_nxt = 1'b0;
                        ev[eea_pkg::IRQ_DONE] = 1'b1;
                        if (!wr_cyc_r) begin
                            dat_nxt = rx_r;
                        end
                    end
                end
            end
            default: st_nxt = eea_pkg::ST_IDLE;
        endcase
        // set wins over a clear in the same cycle
        sts_nxt = sts_r;
        if (wr && addr == eea_pkg::OFF_IRQ_CLR) begin
            sts_nxt = sts_r & ~wdata[eea_pkg::IRQ_W-1:0];
        end
        sts_nxt = sts_nxt | ev;
    end

    // registers only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            go_r <= 1'b0;
            cmd_r <= 1'b0;
            err_r <= 1'b0;
            div_r <= eea_pkg::DIV_RESET;
            aldis_r <= 1'b0;
            fast_r <= eea_pkg::FAST_RESET;
            adr_r <= 7'h00;
            dat_r <= 16'h0000;
            al_pend_r <= 1'b1;
            al_busy_r <= 1'b0;
            al_done_r <= 1'b0;
            al_idx_r <= 1'b0;
            svid_r <= eea_pkg::SUBSYS_RESET;
            sid_r <= eea_pkg::SUBSYS_RESET;
            st_r <= eea_pkg::ST_IDLE;
            cyc_busy_r <= 1'b0;
            wr_cyc_r <= 1'b0;
            cnt_r <= 12'h000;
            ph_r <= 2'h0;
            idx_r <= 5'h00;
            tx_r <= 27'h0000000;
            rx_r <= 16'h0000;
            scl_r <= 1'b1;
            drv_r <= 1'b0;
            sts_r <= '0;
            en_r <= '0;
            rdata_r <= 32'h0000_0000;
        end else begin
            go_r <= go_nxt;
            cmd_r <= cmd_nxt;
            err_r <= err_nxt;
            div_r <= div_nxt;
            aldis_r <= aldis_nxt;
            fast_r <= fast_nxt;
            adr_r <= adr_nxt;
            dat_r <= dat_nxt;
            al_pend_r <= al_pend_nxt;
            al_busy_r <= al_busy_nxt;
            al_done_r <= al_done_nxt;
            al_idx_r <= al_idx_nxt;
            svid_r <= svid_nxt;
            sid_r <= sid_nxt;
            st_r <= st_nxt;
            cyc_busy_r <= cyc_busy_nxt;
            wr_cyc_r <= wr_cyc_nxt;
            cnt_r <= cnt_nxt;
            ph_r <= ph_nxt;
            idx_r <= idx_nxt;
            tx_r <= tx_nxt;
            rx_r <= rx_nxt;
            scl_r <= scl_nxt;
            drv_r <= drv_nxt;
            sts_r <= sts_nxt;
            en_r <= en_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // pins: open-drain data, never driven high
    assign ee_scl = scl_r;
    assign ee_sda_o = 1'b0;
    assign ee_sda_oe_n = ~drv_r;
    assign rdata = rdata_r;
    assign irq = |(sts_r & en_r);

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_sw_end;
        fin && !al_busy_r;
    endsequence
    a_go_self_clear: assert property (s_sw_end |=> !go_r)
        else $error("start bit not cleared after access");
    a_start_launch: assert property (launch_sw |=> st_r == eea_pkg::ST_START ##0 cyc_busy_r)
        else $error("access did not launch");
    a_ack_error: assert property (st_r == eea_pkg::ST_BITS && tick && ph_r == 2'h1 &&
        ack_slot && ee_sda_i |=> err_r)
        else $error("missing acknowledge not flagged");
    a_done_excl: assert property (al_done_r |-> !al_busy_r && !al_pend_r)
        else $error("autoload done while still loading");
    a_div_fast3: assert property (tick && !al_busy_r && div_r == 2'h3 |=> cnt_r == 12'h03f)
        else $error("divide by 128 half period wrong");
    a_aldis_hold: assert property (st_r == eea_pkg::ST_IDLE && aldis_r |=> !al_busy_r)
        else $error("autoload ran while disabled");
    a_fast_load: assert property (tick && al_busy_r && fast_r && div_r == 2'h0
        |=> cnt_r == 12'h03f)
        else $error("fast autoload rate wrong");
    a_busy_read: assert property (rd && addr == eea_pkg::OFF_CTL
        |=> rdata[eea_pkg::CTL_ALBUSY] == $past(al_busy_r))
        else $error("in-progress flag misreported");
    a_addr_use: assert property (launch_sw |=> tx_r[26:20] == $past(adr_r))
        else $error("word address not used");
    a_read_load: assert property (s_sw_end ##0 !wr_cyc_r |=> dat_r == $past(rx_r))
        else $error("read word not loaded");
    a_err_clear: assert property (launch_sw || launch_al |=> !err_r)
        else $error("error flag not cleared at start");
endmodule
`default_nettype wire

//--- eea_eeprom_model.sv
`timescale 1ns/1ps
`default_nettype none
module eea_eeprom_model #(
    parameter logic [15:0] W0 = 16'h3c5a, // arbitrary word 0 content
    parameter logic [15:0] W1 = 16'ha5c3 // arbitrary word 1 content
) (
    // serial pins
    input wire logic scl,
    input wire logic sda,
    // test control: withhold every acknowledge
    input wire logic nack,
    // open-drain pull, low pulls the line
    output logic sda_oe_n,
    // slot count inside the frame, for timing checks
    output logic [5:0] slot
);
    logic [15:0] mem [0:127]; // word storage
    logic [7:0] hdr; // word address and direction
    logic [15:0] sh; // incoming write word
    logic act; // inside a frame
    initial begin
        act = 1'b0;
        slot = 6'h00;
        sda_oe_n = 1'b1;
        hdr = 8'h00;
        sh = 16'h0000;
        mem[0] = W0;
        mem[1] = W1;
    end
    // start: data falls while clock high; settle first, since the master moves
    // clock and data on one core edge and the order of those updates is not fixed
    always @(negedge sda) begin
        #1;
        if (scl === 1'b1 && sda === 1'b0) begin
            act = 1'b1;
            slot = 6'h00;
        end
    end
    // stop: data rises while clock high, line left to the pull-up
    always @(posedge sda) begin
        #1;
        if (scl === 1'b1 && sda === 1'b1) begin
            act = 1'b0;
            sda_oe_n = 1'b1;
        end
    end
    // sample on clock rise, msb first
    always @(posedge scl) begin
        if (act) begin
            if (slot < 6'd8) begin
                hdr = {hdr[6:0], sda};
            end else if (slot > 6'd8 && slot != 6'd17 && slot < 6'd26) begin
                sh = {sh[14:0], sda};
            end
            // a refused write leaves the word untouched
            if (slot == 6'd25 && !hdr[0] && !nack) begin
                mem[hdr[7:1]] = sh;
            end
            slot = slot + 6'd1;
        end
    end
    // drive on clock fall so the level is settled at the next rise
    always @(negedge scl) begin
        if (act) begin
            if (slot == 6'd8 || (!hdr[0] && (slot == 6'd17 || slot == 6'd26))) begin
                sda_oe_n = nack;
            end else if (hdr[0] && slot > 6'd8 && slot < 6'd25) begin
                sda_oe_n = mem[hdr[7:1]][24 - slot];
            end else begin
                sda_oe_n = 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    // clock, reset and register port
    logic clk, rst_n, wr, rd;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    // serial side and interrupt
    logic ee_scl, ee_sda_oe_n, sda_o, irq, mdl_oe_n, nack;
    logic [5:0] slot;
    // pull-up line: eeprom pulls low, block shows its data pin while enabled
    wire logic sda = !mdl_oe_n ? 1'b0 : (!ee_sda_oe_n ? sda_o : 1'b1);
    // bookkeeping
    int n_mismatch, n_tests, seed, cyc, i;
    logic [31:0] exp_q[$], msk_q[$], last_rd, e, m, per;
    logic rd_q;
    time t_last;
    logic [6:0] a;
    logic [15:0] d, d0;
    localparam logic [15:0] W0 = 16'h3c5a; // arbitrary
    localparam logic [15:0] W1 = 16'ha5c3; // arbitrary

    eea_autoload eea_autoload_i (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .ee_scl(ee_scl), .ee_sda_i(sda),
        .ee_sda_o(sda_o), .ee_sda_oe_n(ee_sda_oe_n), .irq(irq));
    eea_eeprom_model #(.W0(W0), .W1(W1)) eea_eeprom_model_i (.scl(ee_scl), .sda(sda),
        .nack(nack), .sda_oe_n(mdl_oe_n), .slot(slot));

    // free-running core clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // read data stands only in the cycle after the strobe; zero mask marks a poll
    always @(posedge clk) begin
        rd_q <= rd;
        cyc <= cyc + 1;
        if (rd_q === 1'b1 && msk_q.size() > 0) begin
            last_rd = rdata;
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            if (m != 32'h0) check(rdata & m, e & m, "read data");
        end
        // hang guard, well above the expected run
        if (cyc > 60000) begin
            n_mismatch++;
            test_done();
        end
    end

    // serial clock period between data bits
    always @(posedge ee_scl) begin
        if (slot > 6'd2 && slot < 6'd20) per = 32'($time - t_last);
        t_last = $time;
    end

    // an extra idle edge keeps strobe lowering and raising apart
    task automatic reg_wr(input logic [7:0] ad, input logic [31:0] dt);
        addr <= ad;
        wdata <= dt;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic reg_rd(input logic [7:0] ad, input logic [31:0] ex, input logic [31:0] mk_);
        exp_q.push_back(ex);
        msk_q.push_back(mk_);
        addr <= ad;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask

    // poll the control word until bit b reads zero
    task automatic wait_clear(input int b);
        int k;
        for (k = 0; k < 400; k++) begin
            reg_rd(eea_pkg::OFF_CTL, 32'h0, 32'h0);
            @(posedge clk);
            if (last_rd[b] === 1'b0) break;
            repeat (20) @(posedge clk);
        end
    endtask

    function automatic logic [31:0] mk(input logic [15:0] dt, input logic [6:0] ad,
        input logic [1:0] dv, input logic cmd, input logic go);
        mk = {dt, ad, 1'b0, 1'b1, 1'b0, dv, 2'b00, cmd, go};
    endfunction

    // one single-word access at the fastest divisor, then the control word
    task automatic access(input logic [15:0] dt, input logic [6:0] ad, input logic cmd,
        input logic [31:0] ex);
        reg_wr(eea_pkg::OFF_CTL, mk(dt, ad, 2'h3, cmd, 1'b1));
        wait_clear(eea_pkg::CTL_GO);
        reg_rd(eea_pkg::OFF_CTL, ex, 32'hffffffff);
    endtask

    initial begin
        seed = 17;
        n_mismatch = 0;
        n_tests = 0;
        cyc = 0;
        rd_q = 1'b0;
        nack = 1'b0;
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        t_last = 0;
        per = 32'h0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        // autoload starts on its own at release
        reg_rd(eea_pkg::OFF_CTL, 32'h00000180, 32'hffffffff);
        reg_rd(eea_pkg::OFF_SUBSYS, 32'h0, 32'hffffffff);
        reg_rd(eea_pkg::OFF_RSVD, 32'h0, 32'hffffffff);
        reg_rd(8'hfc, 32'h0, 32'hffffffff);
        wait_clear(eea_pkg::CTL_ALBUSY);
        reg_rd(eea_pkg::OFF_CTL, 32'h00000088, 32'hffffffff);
        reg_wr(eea_pkg::OFF_SUBSYS, 32'hffffffff);
        reg_rd(eea_pkg::OFF_SUBSYS, {W1, W0}, 32'hffffffff);
        // divisor codes; status bits ignore writes
        for (i = 0; i < 4; i++) begin
            // odd codes also clear the fast bit; every code sets the load disable
            reg_wr(eea_pkg::OFF_CTL, (mk(16'h0, 7'h0, i[1:0], 1'b0, 1'b0) ^
                {24'h0, i[0], 7'h00}) | 32'h14c);
            reg_rd(eea_pkg::OFF_CTL, (mk(16'h0, 7'h0, i[1:0], 1'b0, 1'b0) ^
                {24'h0, i[0], 7'h00}) | 32'h48, 32'hffffffff);
        end
        reg_wr(eea_pkg::OFF_IRQ_CLR, 32'h7);
        reg_wr(eea_pkg::OFF_IRQ_EN, 32'h2);
        reg_rd(eea_pkg::OFF_IRQ_EN, 32'h2, 32'hffffffff);
        reg_rd(eea_pkg::OFF_IRQ_STS, 32'h0, 32'hffffffff);
        // write then read back, top address and a random one
        for (i = 0; i < 2; i++) begin
            a = (i == 0) ? 7'h7f : 7'($random(seed));
            d = 16'($random(seed));
            // a random repeat of the top address overwrites it
            if (a == 7'h7f) d0 = d;
            access(d, a, 1'b1, mk(d, a, 2'h3, 1'b1, 1'b0) | 32'h8);
            check({16'h0, eea_eeprom_model_i.mem[a]}, {16'h0, d}, "stored word");
            check(per, 32'd1280, "serial clock period");
            access(16'h0, a, 1'b0, mk(d, a, 2'h3, 1'b0, 1'b0) | 32'h8);
            @(negedge clk);
            check({31'h0, irq}, 32'h0, "masked interrupt");
        end
        reg_rd(eea_pkg::OFF_IRQ_STS, 32'h1, 32'hffffffff);
        // every acknowledge withheld
        nack <= 1'b1;
        access(16'hbeef, 7'h05, 1'b1, mk(16'hbeef, 7'h05, 2'h3, 1'b1, 1'b0) | 32'hc);
        nack <= 1'b0;
        @(negedge clk);
        check({31'h0, irq}, 32'h1, "error interrupt");
        reg_rd(eea_pkg::OFF_IRQ_STS, 32'h3, 32'hffffffff);
        reg_wr(eea_pkg::OFF_IRQ_CLR, 32'h2);
        @(negedge clk);
        check({31'h0, irq}, 32'h0, "interrupt cleared");
        reg_rd(eea_pkg::OFF_IRQ_STS, 32'h1, 32'hffffffff);
        // the next good cycle clears the flag
        access(16'h0, 7'h7f, 1'b0, mk(d0, 7'h7f, 2'h3, 1'b0, 1'b0) | 32'h8);
        test_done();
    end
endmodule
`default_nettype wire
